// ---- dv/test_timer_interval_event_count.sv ----
// bench for the interval and event count timer
`timescale 1ns/1ps
`include "tiec_map.svh"
module test_timer_interval_event_count;
   logic        sys_clk, rst_n, regWrStb, regRdStb, burst, pin, busy;
   logic        timerOutA, timerOutB, periodMatchIrq, secondMatchIrq;
   logic [7:0]  regAddr, edges;
   logic [3:0]  halfCyc;
   logic [31:0] regWrData, regRdData, v, w;
   int          num_errors, checked, pIrq, sIrq, pB, sB, n;

   tiec_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .eventInputPin(pin), .timerOutA(timerOutA),
      .timerOutB(timerOutB), .periodMatchIrq(periodMatchIrq),
      .secondMatchIrq(secondMatchIrq));
   tiec_event_src u_src (.sys_clk(sys_clk), .rst_n(rst_n), .burst(burst),
      .edges(edges), .halfCyc(halfCyc), .pinOut(pin), .busy(busy));

   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (periodMatchIrq === 1'b1) pIrq <= pIrq + 1;
      if (secondMatchIrq === 1'b1) sIrq <= sIrq + 1;
   end

   // ====
   // access tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr   <= a;
      regWrData <= d;
      regWrStb  <= 1'b1;
      regRdStb  <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      regAddr  <= a;
      regRdStb <= 1'b1;
      regWrStb <= 1'b0;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1 d = regRdData;
      @(posedge sys_clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a, v);
      chk(v, e);
   endtask
   task automatic idle(input int c);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
      repeat (c) @(posedge sys_clk);
   endtask
   task automatic dchk(input int ep, input int es);
      chk(32'(pIrq - pB), 32'(ep));
      chk(32'(sIrq - sB), 32'(es));
   endtask
   task automatic ochk(input logic [1:0] m, input logic [1:0] e);
      chk({30'h0, {timerOutA, timerOutB} & m}, {30'h0, e});
   endtask
   task automatic send(input int k, input logic [3:0] h);
      burst   <= 1'b1;
      edges   <= 8'(k);
      halfCyc <= h;
      idle(1);
      burst <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 400 && busy; i++) @(posedge sys_clk);
      chk({31'h0, busy}, 32'h0);
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic complete_run;
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge sys_clk);
      num_errors++;
      complete_run();
   end

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      burst = 1'b0;
      edges = 8'h00;
      halfCyc = 4'h2;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      // ====
      // reset state and refused accesses
      rdc(`TIEC_OFS_COUNT, 32'hffff);
      rdc(`TIEC_OFS_IRQCTL, 32'h3);
      rdc(8'h3c, 32'h0);
      wr(`TIEC_OFS_COUNT, 32'h1234);
      rdc(`TIEC_OFS_COUNT, 32'hffff);
      // ====
      // event count mode, period 3
      wr(`TIEC_OFS_IRQCTL, 32'h0);
      wr(`TIEC_OFS_PERIOD, 32'h3);
      rdc(`TIEC_OFS_PERIOD, 32'h3);
      wr(`TIEC_OFS_SECOND, 32'h2);
      rdc(`TIEC_OFS_SECOND, 32'h2);
      wr(`TIEC_OFS_EVTCTL, 32'h4);
      wr(`TIEC_OFS_CAPCTL, 32'h0);
      wr(`TIEC_OFS_OUTCTL, 32'h0);
      wr(`TIEC_OFS_CTRL1, 32'h1);
      wr(`TIEC_OFS_CTRL0, 32'h80);
      idle(2);
      pB = pIrq;
      sB = sIrq;
      rdc(`TIEC_OFS_COUNT, 32'h0);
      send(3, 4'h2);
      rdc(`TIEC_OFS_COUNT, 32'h3);
      dchk(1, 1);
      send(3, 4'h3);
      rdc(`TIEC_OFS_COUNT, 32'h2);
      dchk(1, 2);
      send(1, 4'h2);
      dchk(2, 2);
      ochk(2'b11, 2'b00);
      // ====
      // interval mode clocked by event edges, both compares one
      wr(`TIEC_OFS_CTRL0, 32'h0);
      wr(`TIEC_OFS_PERIOD, 32'h1);
      wr(`TIEC_OFS_SECOND, 32'h1);
      wr(`TIEC_OFS_CTRL1, 32'h20);
      wr(`TIEC_OFS_OUTCTL, 32'h5);
      rdc(`TIEC_OFS_COUNT, 32'hffff);
      wr(`TIEC_OFS_CTRL0, 32'h80);
      idle(4);
      rdc(`TIEC_OFS_COUNT, 32'hffff);
      pB = pIrq;
      sB = sIrq;
      send(1, 4'h2);
      rdc(`TIEC_OFS_COUNT, 32'h0);
      ochk(2'b11, 2'b10);
      send(1, 4'h2);
      ochk(2'b01, 2'b01);
      send(1, 4'h2);
      ochk(2'b11, 2'b01);
      send(1, 4'h2);
      ochk(2'b01, 2'b00);
      dchk(2, 2);
      // ====
      // event count on both pin edges, outputs left enabled
      wr(`TIEC_OFS_CTRL0, 32'h0);
      wr(`TIEC_OFS_EVTCTL, 32'hc);
      wr(`TIEC_OFS_CTRL1, 32'h1);
      wr(`TIEC_OFS_PERIOD, 32'h3);
      wr(`TIEC_OFS_CTRL0, 32'h80);
      idle(2);
      pB = pIrq;
      sB = sIrq;
      send(2, 4'h2);
      dchk(1, 1);
      rdc(`TIEC_OFS_COUNT, 32'h0);
      ochk(2'b11, 2'b00);
      // ====
      // internal clock, second above then below period
      wr(`TIEC_OFS_CTRL0, 32'h0);
      wr(`TIEC_OFS_CTRL1, 32'h0);
      wr(`TIEC_OFS_SECOND, 32'h9);
      wr(`TIEC_OFS_PERIOD, 32'h4);
      pB = pIrq;
      sB = sIrq;
      wr(`TIEC_OFS_CTRL0, 32'h80);
      idle(60);
      ochk(2'b01, 2'b00);
      chk(32'(sIrq - sB), 32'h0);
      n = pIrq - pB;
      chk(32'(n > 10 && n < 14), 32'h1);
      wr(`TIEC_OFS_CTRL0, 32'h0);
      wr(`TIEC_OFS_SECOND, 32'h2);
      pB = pIrq;
      sB = sIrq;
      wr(`TIEC_OFS_CTRL0, 32'h80);
      idle(60);
      n = (sIrq - sB) - (pIrq - pB);
      chk(32'((n == 0 || n == 1) && sIrq - sB > 9), 32'h1);
      // ====
      // live readback, then period shrunk below the count
      wr(`TIEC_OFS_CTRL0, 32'h0);
      wr(`TIEC_OFS_PERIOD, 32'h40);
      wr(`TIEC_OFS_CTRL0, 32'h80);
      idle(30);
      rd(`TIEC_OFS_COUNT, v);
      rd(`TIEC_OFS_COUNT, w);
      chk(w - v, 32'h2);
      wr(`TIEC_OFS_PERIOD, 32'h8);
      idle(1);
      pB = pIrq;
      for (n = 0; n < 70000 && pIrq == pB; n++) @(posedge sys_clk);
      n = n + int'(w);
      chk(32'(n > 65536 && n < 65556), 32'h1);
      pB = pIrq;
      for (n = 0; n < 100 && pIrq == pB; n++) @(posedge sys_clk);
      chk(32'(n), 32'h9);
      complete_run();
   end
endmodule // test_timer_interval_event_count

// ---- dv/tiec_event_src.sv ----
// event source model driving the timer's event input pin
`timescale 1ns/1ps
module tiec_event_src (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       burst,
   input  wire logic [7:0] edges,
   input  wire logic [3:0] halfCyc,
   output logic            pinOut,
   output logic            busy
);
   logic [7:0] left_ff;
   logic [3:0] tmr_ff;
   logic       pin_ff;

   assign pinOut = pin_ff;
   assign busy   = (left_ff != 8'h00);

   // ====
   // pulse train, idle low, halfCyc clocks per level
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         left_ff <= 8'h00;
         tmr_ff  <= 4'h0;
         pin_ff  <= 1'b0;
      end else if (burst) begin
         left_ff <= edges;
         tmr_ff  <= halfCyc;
      end else if (busy) begin
         if (tmr_ff > 4'h1) begin
            tmr_ff <= tmr_ff - 4'h1;
         end else begin
            tmr_ff <= halfCyc;
            pin_ff <= ~pin_ff;
            if (pin_ff) begin
               left_ff <= left_ff - 8'h01;
            end
         end
      end
   end
endmodule // tiec_event_src

// ---- dv/tiec_timer_monitor.sv ----
// assertions on the timer's register port and outputs
`timescale 1ns/1ps
`include "tiec_map.svh"
module tiec_timer_monitor (
   input wire logic                    sys_clk,
   input wire logic                    rst_n,
   input wire logic [`TIEC_ADDR_W-1:0] regAddr,
   input wire logic [31:0]             regWrData,
   input wire logic                    regWrStb,
   input wire logic                    regRdStb,
   input wire logic [31:0]             regRdData,
   input wire logic                    eventInputPin,
   input wire logic                    timerOutA,
   input wire logic                    timerOutB,
   input wire logic                    periodMatchIrq,
   input wire logic                    secondMatchIrq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // ====
   // register port
   a_rd_idle_zero:
      assert property (!$past(regRdStb) |-> regRdData == 32'h0)
      else $error("read data outside read slot");
   a_rd_upper_zero:
      assert property (regRdData[31:16] == 16'h0)
      else $error("upper read bits set");
   a_rd_unmapped:
      assert property (regRdStb && regAddr == 8'h3c |=> regRdData == 32'h0)
      else $error("unmapped read not zero");
   a_period_echo:
      assert property (regWrStb && regAddr == `TIEC_OFS_PERIOD ##1
         regRdStb && regAddr == `TIEC_OFS_PERIOD
         |=> regRdData[15:0] == $past(regWrData[15:0], 2))
      else $error("period compare readback wrong");
   a_second_echo:
      assert property (regWrStb && regAddr == `TIEC_OFS_SECOND ##1
         regRdStb && regAddr == `TIEC_OFS_SECOND
         |=> regRdData[15:0] == $past(regWrData[15:0], 2))
      else $error("second compare readback wrong");

   // ====
   // interrupts and outputs
   a_period_pulse:
      assert property (periodMatchIrq |=> !periodMatchIrq)
      else $error("period irq longer than one cycle");
   a_second_pulse:
      assert property (secondMatchIrq |=> !secondMatchIrq)
      else $error("second irq longer than one cycle");
   a_outb_by_match:
      assert property ($changed(timerOutB) && !$past(regWrStb)
         |-> ##[0:2] secondMatchIrq)
      else $error("out b moved without second match");

   c_both_irq: cover property (periodMatchIrq && secondMatchIrq);
   c_outb_flip: cover property ($changed(timerOutB));
   c_count_read: cover property (regRdStb && regAddr == `TIEC_OFS_COUNT);
endmodule // tiec_timer_monitor

bind tiec_timer tiec_timer_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
   .regRdStb(regRdStb), .regRdData(regRdData),
   .eventInputPin(eventInputPin), .timerOutA(timerOutA),
   .timerOutB(timerOutB), .periodMatchIrq(periodMatchIrq),
   .secondMatchIrq(secondMatchIrq));

// ---- rtl/tiec_edge_det.sv ----
// event pin synchroniser and valid edge detector
`timescale 1ns/1ps
module tiec_edge_det (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             pinIn,
   input  wire tiec_pkg::tiec_edge_t edgeSel,
   output logic                  edgePulse
);

   logic syncA_ff;
   logic syncB_ff;
   logic prev_ff;

   // ==========================================================
   // two-stage synchroniser plus history
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         syncA_ff <= 1'b0;
         syncB_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         syncA_ff <= pinIn;
         syncB_ff <= syncA_ff;
         prev_ff  <= syncB_ff;
      end
   end

   // ==========================================================
   // edge selection
   always_comb begin
      case (edgeSel)
         tiec_pkg::EDGE_RISING:  edgePulse = syncB_ff & ~prev_ff;
         tiec_pkg::EDGE_FALLING: edgePulse = ~syncB_ff & prev_ff;
         tiec_pkg::EDGE_BOTH:    edgePulse = syncB_ff ^ prev_ff;
         default:                edgePulse = 1'b0;
      endcase
   end

endmodule // tiec_edge_det

// ---- rtl/tiec_map.svh ----
// register offsets, field positions, reset values and counts of the timer
// Functional notes
// - equal compare values: second irq coincides with period irq, out B 50% duty
// - second compare below period: one second irq and B toggle per cycle
// - second compare above period: no second irq, out B unchanged
// - interval event counting: enable moves count all ones to zero on an edge
// - both compares one with event clock: out B toggles every two counts
// - event count mode 001 counts valid edges, period irq on match
// - event count mode drives neither timer output
// - event mode enable: count all ones to zero, period shadow loaded
// - event mode count equal to period shadow clears count, irq
// - first period irq after D edges, later ones after D plus one
// - event mode still loads second shadow and raises second irq
// - external count clock only via event pin; capture edges left off
// - period all ones: count reaches all ones, clears next, no wrap flag
// - period rewrite loads shadow at once; smaller value wraps count
// - count readback returns live counter without disturbing it
// - interval mode 000: period match clears count, toggles A, irq
// - interval mode: second match toggles B and raises second irq
`ifndef TIEC_MAP_SVH
`define TIEC_MAP_SVH

`define TIEC_ADDR_W       8
`define TIEC_OFS_CTRL0    8'h00
`define TIEC_OFS_CTRL1    8'h04
`define TIEC_OFS_OUTCTL   8'h08
`define TIEC_OFS_CAPCTL   8'h0c
`define TIEC_OFS_EVTCTL   8'h10
`define TIEC_OFS_PERIOD   8'h18
`define TIEC_OFS_SECOND   8'h1c
`define TIEC_OFS_COUNT    8'h20
`define TIEC_OFS_IRQCTL   8'h24

`define TIEC_CTRL0_CE     7
`define TIEC_CTRL1_EEE    5
`define TIEC_OUT_OE0      0
`define TIEC_OUT_OL0      1
`define TIEC_OUT_OE1      2
`define TIEC_OUT_OL1      3
`define TIEC_IRQ_MSK0     0
`define TIEC_IRQ_MSK1     1

`define TIEC_CNT_W        16
`define TIEC_CNT_ONES     16'hffff
`define TIEC_CNT_ZERO     16'h0000
`define TIEC_CMP_RST      16'hffff
`define TIEC_IRQCTL_RST   2'h3
`define TIEC_PRE_W        8

`endif

// ---- rtl/tiec_pkg.sv ----
// types shared by the interval and event count timer
package tiec_pkg;

   typedef enum logic [2:0] {
      MODE_INTERVAL = 3'h0,
      MODE_EVENT    = 3'h1
   } tiec_mode_t;

   typedef enum logic [1:0] {
      EDGE_NONE    = 2'h0,
      EDGE_RISING  = 2'h1,
      EDGE_FALLING = 2'h2,
      EDGE_BOTH    = 2'h3
   } tiec_edge_t;

   typedef enum {
      ST_IDLE,
      ST_START,
      ST_RUN
   } tiec_state_t;

endpackage

// ---- rtl/tiec_prescale.sv ----
// internal count clock divider, power-of-two ratios
`timescale 1ns/1ps
`include "tiec_map.svh"
module tiec_prescale (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [2:0] divSel,
   output logic            tick
);

   logic [`TIEC_PRE_W-1:0] div_ff;
   logic [`TIEC_PRE_W-1:0] limit;

   assign limit = `TIEC_PRE_W'((1 << divSel) - 1);
   assign tick  = run && (div_ff == limit);

   // ==========================================================
   // free divider, restarts whenever counting stops
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         div_ff <= '0;
      end else if (!run || tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + `TIEC_PRE_W'(1);
      end
   end

endmodule // tiec_prescale

// ---- rtl/tiec_timer.sv ----
// 16-bit interval and event count timer with compare shadows
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "tiec_map.svh"
module tiec_timer (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic [`TIEC_ADDR_W-1:0] regAddr,
   input  wire logic [31:0]             regWrData,
   input  wire logic                    regWrStb,
   input  wire logic                    regRdStb,
   output logic      [31:0]             regRdData,
   input  wire logic                    eventInputPin,
   output logic                         timerOutA,
   output logic                         timerOutB,
   output logic                         periodMatchIrq,
   output logic                         secondMatchIrq
);

   // ==========================================================
   // software visible registers
   logic                    countEnable_ff;
   logic [2:0]              prescaleSel_ff;
   tiec_pkg::tiec_mode_t    mode_ff;
   logic                    eventClockSel_ff;
   logic [3:0]              outputControl_ff;
   logic [1:0]              captureEdgeSel_ff;
   tiec_pkg::tiec_edge_t    eventEdgeSel_ff;
   logic [`TIEC_CNT_W-1:0]  periodCompare_ff;
   logic [`TIEC_CNT_W-1:0]  secondCompare_ff;
   logic [1:0]              irqMask_ff;
   logic [31:0]             rdData_ff;

   // ==========================================================
   // counting state
   tiec_pkg::tiec_state_t   state_ff;
   tiec_pkg::tiec_state_t   nxt_state;
   logic [`TIEC_CNT_W-1:0]  count_ff;
   logic [`TIEC_CNT_W-1:0]  nxt_count;
   logic [`TIEC_CNT_W-1:0]  periodShadow_ff;
   logic [`TIEC_CNT_W-1:0]  secondShadow_ff;
   logic                    outA_ff;
   logic                    outB_ff;
   logic                    periodIrq_ff;
   logic                    secondIrq_ff;

   logic wrCtrl0;
   logic wrPeriod;
   logic wrSecond;
   logic modeValid;
   logic intervalMode;
   logic eventMode;
   logic useEventClk;
   logic eventTick;
   logic preTick;
   logic countTick;
   logic enableRise;
   logic periodHit;
   logic secondHit;
   logic wrapClear;

   assign wrCtrl0  = regWrStb && (regAddr == `TIEC_OFS_CTRL0);
   assign wrPeriod = regWrStb && (regAddr == `TIEC_OFS_PERIOD);
   assign wrSecond = regWrStb && (regAddr == `TIEC_OFS_SECOND);

   assign intervalMode = (mode_ff == tiec_pkg::MODE_INTERVAL);
   assign eventMode    = (mode_ff == tiec_pkg::MODE_EVENT);
   assign modeValid    = intervalMode || eventMode;

   // external clock enters only via the event pin; capture unused
   assign useEventClk = eventMode || (intervalMode && eventClockSel_ff);

   assign enableRise = wrCtrl0 && regWrData[`TIEC_CTRL0_CE]
                       && !countEnable_ff;

   // ==========================================================
   // count clock sources
   tiec_edge_det u_edge (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .pinIn     (eventInputPin),
      .edgeSel   (eventEdgeSel_ff),
      .edgePulse (eventTick)
   );

   tiec_prescale u_pre (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .run     (countEnable_ff && !useEventClk),
      .divSel  (prescaleSel_ff),
      .tick    (preTick)
   );

   assign countTick = useEventClk ? eventTick : preTick;

   // ==========================================================
   // register writes
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         countEnable_ff <= 1'b0;
         prescaleSel_ff <= 3'h0;
      end else if (wrCtrl0) begin
         countEnable_ff <= regWrData[`TIEC_CTRL0_CE];
         prescaleSel_ff <= regWrData[2:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_ff          <= tiec_pkg::MODE_INTERVAL;
         eventClockSel_ff <= 1'b0;
         outputControl_ff <= 4'h0;
         captureEdgeSel_ff <= 2'h0;
         eventEdgeSel_ff  <= tiec_pkg::EDGE_NONE;
         irqMask_ff       <= `TIEC_IRQCTL_RST;
      end else if (regWrStb) begin
         case (regAddr)
            `TIEC_OFS_CTRL1: begin
               mode_ff          <= tiec_pkg::tiec_mode_t'(regWrData[2:0]);
               eventClockSel_ff <= regWrData[`TIEC_CTRL1_EEE];
            end
            `TIEC_OFS_OUTCTL: outputControl_ff  <= regWrData[3:0];
            `TIEC_OFS_CAPCTL: captureEdgeSel_ff <= regWrData[1:0];
            `TIEC_OFS_EVTCTL: begin
               eventEdgeSel_ff <= tiec_pkg::tiec_edge_t'(regWrData[3:2]);
            end
            `TIEC_OFS_IRQCTL: irqMask_ff <= regWrData[1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         periodCompare_ff <= `TIEC_CMP_RST;
         secondCompare_ff <= `TIEC_CMP_RST;
      end else begin
         if (wrPeriod) begin
            periodCompare_ff <= regWrData[`TIEC_CNT_W-1:0];
         end
         if (wrSecond) begin
            secondCompare_ff <= regWrData[`TIEC_CNT_W-1:0];
         end
      end
   end

   // ==========================================================
   // start sequencing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         tiec_pkg::ST_IDLE: begin
            if (enableRise) begin
               nxt_state = tiec_pkg::ST_START;
            end
         end
         tiec_pkg::ST_START: begin
            if (!countEnable_ff) begin
               nxt_state = enableRise ? tiec_pkg::ST_START : tiec_pkg::ST_IDLE;
            end else if (eventMode) begin
               // event mode leaves all ones at once
               nxt_state = tiec_pkg::ST_RUN;
            end else if (countTick && modeValid) begin
               // interval mode burns one count edge leaving all ones
               nxt_state = tiec_pkg::ST_RUN;
            end
         end
         tiec_pkg::ST_RUN: begin
            if (!countEnable_ff) begin
               // stop then restart back to back must not be lost
               nxt_state = enableRise ? tiec_pkg::ST_START : tiec_pkg::ST_IDLE;
            end
         end
         default: nxt_state = tiec_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff <= tiec_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // counter and match detection
   assign wrapClear = (count_ff == periodShadow_ff);
   assign periodHit = (state_ff == tiec_pkg::ST_RUN) && countTick
                      && modeValid && (nxt_count == periodShadow_ff);
   assign secondHit = (state_ff == tiec_pkg::ST_RUN) && countTick
                      && modeValid && (nxt_count == secondShadow_ff);

   always_comb begin
      if (wrapClear) begin
         nxt_count = `TIEC_CNT_ZERO;
      end else begin
         // past all ones the count rolls over, wrap flag untouched
         nxt_count = count_ff + `TIEC_CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count_ff <= `TIEC_CNT_ONES;
      end else begin
         case (state_ff)
            tiec_pkg::ST_START: begin
               if (nxt_state == tiec_pkg::ST_RUN) begin
                  count_ff <= `TIEC_CNT_ZERO;
               end
            end
            tiec_pkg::ST_RUN: begin
               if (!countEnable_ff) begin
                  count_ff <= `TIEC_CNT_ONES;
               end else if (countTick && modeValid) begin
                  count_ff <= nxt_count;
               end
            end
            default: count_ff <= `TIEC_CNT_ONES;
         endcase
      end
   end

   // ==========================================================
   // compare shadows: loaded at enable and at once on rewrite
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         periodShadow_ff <= `TIEC_CMP_RST;
         secondShadow_ff <= `TIEC_CMP_RST;
      end else begin
         if (wrPeriod) begin
            periodShadow_ff <= regWrData[`TIEC_CNT_W-1:0];
         end else if (enableRise) begin
            periodShadow_ff <= periodCompare_ff;
         end
         if (wrSecond) begin
            secondShadow_ff <= regWrData[`TIEC_CNT_W-1:0];
         end else if (enableRise) begin
            secondShadow_ff <= secondCompare_ff;
         end
      end
   end

   // ==========================================================
   // interrupt pulses, one system clock each
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         periodIrq_ff <= 1'b0;
         secondIrq_ff <= 1'b0;
      end else begin
         // count reaching the period shadow fires the irq
         periodIrq_ff <= periodHit;
         // same moment as period irq when compares are equal
         secondIrq_ff <= secondHit;
      end
   end

   assign periodMatchIrq = periodIrq_ff && !irqMask_ff[`TIEC_IRQ_MSK0];
   assign secondMatchIrq = secondIrq_ff && !irqMask_ff[`TIEC_IRQ_MSK1];

   // ==========================================================
   // timer output levels
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         outA_ff <= 1'b0;
      end else if (state_ff == tiec_pkg::ST_IDLE) begin
         outA_ff <= outputControl_ff[`TIEC_OUT_OL0];
      end else if (intervalMode) begin
         if ((state_ff == tiec_pkg::ST_START)
             && (nxt_state == tiec_pkg::ST_RUN)) begin
            outA_ff <= ~outA_ff;
         end else if (periodHit) begin
            outA_ff <= ~outA_ff;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         outB_ff <= 1'b0;
      end else if (state_ff == tiec_pkg::ST_IDLE) begin
         outB_ff <= outputControl_ff[`TIEC_OUT_OL1];
      end else if (intervalMode && secondHit) begin
         outB_ff <= ~outB_ff;
      end
   end

   // event count mode never drives the outputs
   assign timerOutA = outA_ff && intervalMode
                      && outputControl_ff[`TIEC_OUT_OE0];
   assign timerOutB = outB_ff && intervalMode
                      && outputControl_ff[`TIEC_OUT_OE1];

   // ==========================================================
   // register reads, data valid the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdData_ff <= 32'h0;
      end else if (regRdStb) begin
         case (regAddr)
            `TIEC_OFS_CTRL0: begin
               rdData_ff <= {24'h0, countEnable_ff, 4'h0, prescaleSel_ff};
            end
            `TIEC_OFS_CTRL1: begin
               rdData_ff <= {26'h0, eventClockSel_ff, 2'h0, mode_ff};
            end
            `TIEC_OFS_OUTCTL: rdData_ff <= {28'h0, outputControl_ff};
            `TIEC_OFS_CAPCTL: rdData_ff <= {30'h0, captureEdgeSel_ff};
            `TIEC_OFS_EVTCTL: rdData_ff <= {28'h0, eventEdgeSel_ff, 2'h0};
            `TIEC_OFS_PERIOD: rdData_ff <= {16'h0, periodCompare_ff};
            `TIEC_OFS_SECOND: rdData_ff <= {16'h0, secondCompare_ff};
            `TIEC_OFS_COUNT:  rdData_ff <= {16'h0, count_ff};
            `TIEC_OFS_IRQCTL: rdData_ff <= {30'h0, irqMask_ff};
            default:          rdData_ff <= 32'h0;
         endcase
      end else begin
         rdData_ff <= 32'h0;
      end
   end

   assign regRdData = rdData_ff;

endmodule // tiec_timer
